// ==== hw/dam_pkg.sv ====
package dam_pkg;

    // Register byte addresses on the APB side
    localparam logic [31:0] DAM_SYNC_CTRL_ADDR = 32'h0FFFFC04;
    localparam logic [31:0] DAM_MEM_CFG_ADDR = 32'hFFFFFC00;
    localparam logic [31:0] DAM_STATUS_ADDR = 32'hFFFFFC08;

    // Values after reset
    localparam logic [15:0] DAM_SYNC_CTRL_RST = 16'h0000;
    localparam logic [15:0] DAM_MEM_CFG_RST = 16'h0000;

    // Synchronous memory control fields
    localparam int DAM_SYNC_EN_BIT = 15;
    localparam int DAM_SYNC_COL0_BIT = 6;

    // Memory configuration fields
    localparam int DAM_MD12_LSB = 14;
    localparam int DAM_ROW0_LSB = 12;
    localparam int DAM_MD11_BIT = 11;
    localparam int DAM_ROW8_BIT = 10;
    localparam int DAM_ROW9_BIT = 9;
    localparam int DAM_ROW10_BIT = 8;
    localparam int DAM_COL9_BIT = 7;
    localparam int DAM_COL10_BIT = 6;
    localparam int DAM_MD8_BIT = 5;

    // Status word fields
    localparam int DAM_STAT_BUSY_BIT = 31;
    localparam int DAM_STAT_COL_BIT = 30;

    // Widths
    localparam int DAM_LINE_W = 25;
    localparam int DAM_PIN_W = 16;

    // Access sequencing states, one-hot
    typedef enum logic [3:0] {
        DAM_ST_IDLE = 4'b0001,
        DAM_ST_ROW = 4'b0010,
        DAM_ST_COL = 4'b0100,
        DAM_ST_PLAIN = 4'b1000
    } dam_state_e;

    // Request from the strobe sequencer, same clock
    typedef struct packed {
        logic start;
        logic finish;
        logic isDram;
        logic colStrobe;
    } dam_acc_req_s;

    // Source selections frozen for one access
    typedef struct packed {
        logic sync_dram_enable;
        logic sdCol;
        logic [1:0] md12Sel;
        logic [1:0] row0Sel;
        logic md11Sel;
        logic row8Sel;
        logic row9Sel;
        logic row10Sel;
        logic col9Sel;
        logic col10Sel;
        logic md8Col;
    } dam_sel_s;

endpackage

// ==== hw/dam_addr_mux.sv ====
// Local design decision: the APB slave port.
module dam_addr_mux (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dam_pkg::dam_acc_req_s accReq,
    input wire logic [dam_pkg::DAM_LINE_W-1:0] internalAddressLine,
    output logic [dam_pkg::DAM_PIN_W-1:0] multiplexedDramAddress,
    output logic accessBusy
);
    import dam_pkg::*;

    logic [15:0] syncCtrl_q;
    logic [15:0] memCfg_q;
    logic [31:0] prdata_q;
    dam_state_e state_q;
    dam_state_e state_d;
    dam_sel_s sel_q;
    dam_sel_s selLive;
    dam_sel_s selUse;
    logic [DAM_PIN_W-1:0] pins_q;
    logic [DAM_PIN_W-1:0] pins_d;
    logic [DAM_PIN_W-1:0] rowMap;
    logic [DAM_PIN_W-1:0] colMap;
    logic [DAM_PIN_W-1:0] plainMap;
    logic [DAM_LINE_W-1:0] lineIn;
    logic apbSetup;
    logic apbAccess;
    logic hitSync;
    logic hitCfg;
    logic hitStat;
    logic hitAny;
    logic [31:0] rdMux;
    logic [DAM_LINE_W-1:0] lineDly_q;

    assign lineIn = internalAddressLine;

    // Address decode; whole word compare so aliases are refused
    assign hitSync = (paddr == DAM_SYNC_CTRL_ADDR);
    assign hitCfg = (paddr == DAM_MEM_CFG_ADDR);
    assign hitStat = (paddr == DAM_STATUS_ADDR);
    assign hitAny = hitSync | hitCfg | hitStat;
    assign apbSetup = psel & ~penable;
    assign apbAccess = psel & penable;

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = apbAccess & ~hitAny;
    assign prdata = prdata_q;

    // Read word assembled from registers and live state
    always_comb begin
        rdMux = 32'h00000000;
        if (hitSync) begin
            rdMux = {16'h0000, syncCtrl_q};
        end else if (hitCfg) begin
            rdMux = {16'h0000, memCfg_q};
        end else if (hitStat) begin
            rdMux[DAM_STAT_BUSY_BIT] = (state_q != DAM_ST_IDLE);
            rdMux[DAM_STAT_COL_BIT] = (state_q == DAM_ST_COL);
            rdMux[DAM_PIN_W-1:0] = pins_q;
        end
    end

    // Read data captured in the setup cycle so it is a flop at the access edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h00000000;
        end else if (apbSetup && !pwrite) begin
            prdata_q <= rdMux;
        end
    end

    // Synchronous memory control register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            syncCtrl_q <= DAM_SYNC_CTRL_RST;
        end else if (apbAccess && pwrite && hitSync) begin
            syncCtrl_q <= pwdata[15:0];
        end
    end

    // Memory configuration register holds the mux selections except the sync enable and sdCol
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            memCfg_q <= DAM_MEM_CFG_RST;
        end else if (apbAccess && pwrite && hitCfg) begin
            memCfg_q <= pwdata[15:0];
        end
    end

    // Live view of the selection fields
    always_comb begin
        selLive.sync_dram_enable = syncCtrl_q[DAM_SYNC_EN_BIT];
        selLive.sdCol = syncCtrl_q[DAM_SYNC_COL0_BIT];
        selLive.md12Sel = memCfg_q[DAM_MD12_LSB+:2];
        selLive.row0Sel = memCfg_q[DAM_ROW0_LSB+:2];
        selLive.md11Sel = memCfg_q[DAM_MD11_BIT];
        selLive.row8Sel = memCfg_q[DAM_ROW8_BIT];
        selLive.row9Sel = memCfg_q[DAM_ROW9_BIT];
        selLive.row10Sel = memCfg_q[DAM_ROW10_BIT];
        selLive.col9Sel = memCfg_q[DAM_COL9_BIT];
        selLive.col10Sel = memCfg_q[DAM_COL10_BIT];
        selLive.md8Col = memCfg_q[DAM_MD8_BIT];
    end

    // A register write mid-access must not move the pins, so freeze at start
    assign selUse = accReq.start ? selLive : sel_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sel_q <= '0;
        end else if (accReq.start) begin
            sel_q <= selLive;
        end
    end

    // Access sequencing: row phase, then column phase on the column strobe
    always_comb begin
        state_d = state_q;
        case (state_q)
            DAM_ST_IDLE: begin
                if (accReq.start) begin
                    state_d = accReq.isDram ? DAM_ST_ROW : DAM_ST_PLAIN;
                end
            end
            DAM_ST_ROW: begin
                if (accReq.finish) begin
                    state_d = DAM_ST_IDLE;
                end else if (accReq.colStrobe) begin
                    state_d = DAM_ST_COL;
                end
            end
            DAM_ST_COL: begin
                // Page bursts stay in column phase; the open row is untouched
                if (accReq.finish) begin
                    state_d = DAM_ST_IDLE;
                end else if (accReq.start && !accReq.isDram) begin
                    state_d = DAM_ST_PLAIN;
                end
            end
            DAM_ST_PLAIN: begin
                if (accReq.finish) begin
                    state_d = DAM_ST_IDLE;
                end else if (accReq.start && accReq.isDram) begin
                    state_d = DAM_ST_ROW;
                end
            end
            default: begin
                state_d = DAM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= DAM_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Row map: lines 9 to 24 only, so a burst inside lines 1 to 8 keeps its row
    always_comb begin
        rowMap[7:1] = lineIn[18:12];
        case (selUse.row0Sel)
            2'h1: rowMap[0] = lineIn[22];
            2'h2: rowMap[0] = lineIn[23];
            default: rowMap[0] = lineIn[11];
        endcase
        rowMap[8] = selUse.row8Sel ? lineIn[20] : lineIn[10];
        rowMap[9] = selUse.row9Sel ? lineIn[19] : lineIn[9];
        rowMap[10] = selUse.row10Sel ? lineIn[21] : lineIn[19];
        rowMap[11] = selUse.md11Sel ? lineIn[22] : lineIn[20];
        case (selUse.md12Sel)
            2'h1: rowMap[12] = lineIn[21];
            2'h2: rowMap[12] = lineIn[23];
            default: rowMap[12] = lineIn[10];
        endcase
        rowMap[13] = lineIn[22];
        rowMap[14] = lineIn[23];
        rowMap[15] = lineIn[24];
    end

    // Column map: lower lines on pins 10:0, row map bits on pins 15:11, page mode or synchronous variant
    always_comb begin
        colMap[7:1] = lineIn[8:2];
        if (selUse.sync_dram_enable) begin
            colMap[0] = selUse.sdCol ? lineIn[0] : lineIn[1];
        end else begin
            colMap[0] = lineIn[1];
        end
        if (selUse.md8Col) begin
            colMap[8] = selUse.sync_dram_enable ? lineIn[1] : lineIn[0];
        end else begin
            colMap[8] = lineIn[9];
        end
        colMap[9] = selUse.col9Sel ? lineIn[1] : lineIn[10];
        // Synchronous parts see a low column A10, so auto-precharge stays off
        colMap[10] = (selUse.col10Sel && !selUse.sync_dram_enable) ? lineIn[11] : 1'b0;
        colMap[15:11] = rowMap[15:11];
    end

    // Plain address: byte bit zero is never placed on a pin
    assign plainMap = lineIn[DAM_PIN_W:1];

    // Pin value follows the phase the access enters this edge
    always_comb begin
        case (state_d)
            DAM_ST_ROW: pins_d = rowMap;
            DAM_ST_COL: pins_d = colMap;
            default: pins_d = plainMap;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign multiplexedDramAddress = pins_q;
    assign accessBusy = (state_q != DAM_ST_IDLE);

    // Helper copy of the address for the checks below
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lineDly_q <= '0;
        end else begin
            lineDly_q <= lineIn;
        end
    end

    a_plain_addr: assert property (@(posedge clock) disable iff (!rst_b)
        (state_d == DAM_ST_PLAIN) |=> (pins_q[12:0] == lineDly_q[13:1]))
        else $error("plain address not on pins");

    a_row_low: assert property (@(posedge clock) disable iff (!rst_b)
        (state_d == DAM_ST_ROW) |=> (pins_q[7:1] == lineDly_q[18:12]))
        else $error("row bits wrong");

    a_col_low: assert property (@(posedge clock) disable iff (!rst_b)
        (state_d == DAM_ST_COL) |=> (pins_q[7:1] == lineDly_q[8:2]))
        else $error("column bits wrong");

    a_pin8_col: assert property (@(posedge clock) disable iff (!rst_b)
        (state_d == DAM_ST_COL && !selUse.md8Col) |=> (pins_q[8] == lineDly_q[9]))
        else $error("pin 8 column source wrong");

    a_pin0_sync: assert property (@(posedge clock) disable iff (!rst_b)
        (state_d == DAM_ST_COL && selUse.sync_dram_enable && selUse.sdCol) |=> (pins_q[0] == lineDly_q[0]))
        else $error("pin 0 sync column wrong");

    a_pin0_page: assert property (@(posedge clock) disable iff (!rst_b)
        (state_d == DAM_ST_COL && !selUse.sync_dram_enable) |=> (pins_q[0] == lineDly_q[1]))
        else $error("pin 0 page column wrong");

    a_pin11_row: assert property (@(posedge clock) disable iff (!rst_b)
        (state_d == DAM_ST_ROW && selUse.md11Sel) |=> (pins_q[11] == lineDly_q[22]))
        else $error("pin 11 source wrong");

    a_pin12_row: assert property (@(posedge clock) disable iff (!rst_b)
        (state_d == DAM_ST_ROW && selUse.md12Sel == 2'h2) |=> (pins_q[12] == lineDly_q[23]))
        else $error("pin 12 source wrong");

    a_sel_frozen: assert property (@(posedge clock) disable iff (!rst_b)
        (!accReq.start) |=> $stable(sel_q))
        else $error("selection moved mid access");

    a_row_to_col: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == DAM_ST_ROW && accReq.colStrobe && !accReq.finish) |=> (state_q == DAM_ST_COL))
        else $error("column phase not entered");

    a_cfg_write: assert property (@(posedge clock) disable iff (!rst_b)
        (apbAccess && pwrite && hitCfg) |=> (memCfg_q == $past(pwdata[15:0])))
        else $error("configuration write lost");

endmodule

// ==== test/dam_dram_model.sv ====
module dam_dram_model
    import dam_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire dam_pkg::dam_acc_req_s accReq,
    input wire logic [dam_pkg::DAM_PIN_W-1:0] multiplexedDramAddress,
    output logic [dam_pkg::DAM_PIN_W-1:0] rowAddr,
    output logic [dam_pkg::DAM_PIN_W-1:0] colAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rowDue_q;
    logic colDue_q;
    logic rowOpen_q;

    // Memory latches the pins one cycle after each column request, and after each row request while no row is open, like a strobe edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rowDue_q <= 1'b0;
            colDue_q <= 1'b0;
            rowOpen_q <= 1'b0;
            rowAddr <= '0;
            colAddr <= '0;
        end else begin
            rowDue_q <= accReq.start && accReq.isDram && !rowOpen_q; // An open page keeps its row
            colDue_q <= accReq.colStrobe;
            rowOpen_q <= (rowOpen_q || rowDue_q) && !accReq.finish;
            if (rowDue_q) rowAddr <= multiplexedDramAddress;
            if (colDue_q) colAddr <= multiplexedDramAddress;
        end
    end
endmodule

// ==== test/dam_addr_mux_tb.sv ====
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin failCount++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module dam_addr_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dam_pkg::*;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, accessBusy, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    dam_acc_req_s accReq;
    logic [DAM_LINE_W-1:0] internalAddressLine;
    logic [DAM_PIN_W-1:0] multiplexedDramAddress, rowAddr, colAddr, rowKeep;
    logic [15:0] sc, cfg;
    int failCount, checkCount;
    logic [15:0] scTab [6] = '{16'h0000, 16'h8000, 16'h8040, 16'h0000, 16'h8000, 16'h0000};
    logic [15:0] cfgTab [6] = '{16'h0000, 16'h0000, 16'h5FE0, 16'hA000, 16'hF020, 16'h0060};
    logic [24:0] pats [3] = '{25'h1234567, 25'h0EDCBA9, 25'h1F0F0F0};

    dam_addr_mux dam_addr_mux_inst (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .accReq(accReq), .internalAddressLine(internalAddressLine),
        .multiplexedDramAddress(multiplexedDramAddress), .accessBusy(accessBusy));
    dam_dram_model dam_dram_model_inst (.clock(clock), .rst_b(rst_b), .accReq(accReq),
        .multiplexedDramAddress(multiplexedDramAddress), .rowAddr(rowAddr), .colAddr(colAddr));

    // Free-running 125 MHz clock
    always #4 clock = ~clock;

    // Expected pins: phase 0 row, 1 column, 2 plain
    function automatic logic [15:0] expPins(input logic [1:0] ph, input logic [24:0] p);
        logic [15:0] m;
        logic sd;
        sd = sc[15];
        m[0] = (cfg[13:12] == 2'b01) ? p[22] : (cfg[13:12] == 2'b10) ? p[23] : p[11];
        m[7:1] = p[18:12];
        m[8] = cfg[10] ? p[20] : p[10];
        m[9] = cfg[9] ? p[19] : p[9];
        m[10] = cfg[8] ? p[21] : p[19];
        m[11] = cfg[11] ? p[22] : p[20];
        m[12] = (cfg[15:14] == 2'b01) ? p[21] : (cfg[15:14] == 2'b10) ? p[23] : p[10];
        m[15:13] = p[24:22];
        if (ph == 2'd1) begin
            m[0] = (sd && sc[6]) ? p[0] : p[1];
            m[7:1] = p[8:2];
            m[8] = cfg[5] ? (sd ? p[1] : p[0]) : p[9];
            m[9] = cfg[7] ? p[1] : p[10];
            m[10] = (cfg[6] && !sd) ? p[11] : 1'b0;
        end
        if (ph == 2'd2) m = p[16:1];
        return m;
    endfunction

    // One APB transfer; an idle cycle follows so strobes never toggle twice in a step
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    // One external access; outputs are sampled at edges, before that edge's updates land
    task automatic access(input logic [24:0] p, input logic dram);
        internalAddressLine <= p;
        accReq.start <= 1'b1;
        accReq.isDram <= dram;
        @(posedge clock);
        accReq.start <= 1'b0;
        accReq.colStrobe <= dram;
        @(posedge clock);
        accReq.colStrobe <= 1'b0;
        `CHK(accessBusy, 1'b1)
        if (!dram) `CHK(multiplexedDramAddress, expPins(2'd2, p))
        @(posedge clock);
        accReq.finish <= 1'b1;
        @(posedge clock);
        accReq.finish <= 1'b0;
        @(posedge clock);
        `CHK(accessBusy, 1'b0)
        `CHK(multiplexedDramAddress, p[16:1])
        if (dram) `CHK(rowAddr, expPins(2'd0, p))
        if (dram) `CHK(colAddr, expPins(2'd1, p))
    endtask

    task automatic finishTest();
        if (failCount == 0 && checkCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clock);
        failCount++;
        finishTest();
    end

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        accReq = '0;
        internalAddressLine = '0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        apb(1'b0, DAM_SYNC_CTRL_ADDR, 32'h0);
        `CHK(rd, {16'h0000, DAM_SYNC_CTRL_RST})
        apb(1'b0, DAM_MEM_CFG_ADDR, 32'h0);
        `CHK(rd, {16'h0000, DAM_MEM_CFG_RST})
        apb(1'b0, 32'h00000010, 32'h0);
        `CHK(err, 1'b1)
        // Status after reset: idle, column flag low, plain address of line zero
        apb(1'b0, DAM_STATUS_ADDR, 32'h0);
        `CHK(rd, 32'h00000000)
        // Every field code across page and sync column maps
        for (int i = 0; i < 6; i++) begin
            sc = scTab[i];
            cfg = cfgTab[i];
            apb(1'b1, DAM_SYNC_CTRL_ADDR, {16'h0000, sc});
            apb(1'b1, DAM_MEM_CFG_ADDR, {16'h0000, cfg});
            apb(1'b0, DAM_MEM_CFG_ADDR, 32'h0);
            `CHK(rd, {16'h0000, cfg})
            for (int j = 0; j < 3; j++) begin
                access(pats[j], 1'b1);
                access(pats[j], 1'b0);
            end
            // Neighbouring words of the first pattern share its row
            rowKeep = expPins(2'd0, pats[0]);
            access(pats[0] ^ 25'h00001FE, 1'b1);
            `CHK(rowAddr, rowKeep)
        end
        finishTest();
    end
endmodule
